// [include/mrr_pkg.sv]
// Package: register map, field layout and types for the measurement result registers
// Function
// - Current result holds 14-bit conversion in bits 15:2 while current-amp enable is set.
// - Current conversion is bipolar, taken after the selected current-amp gain is applied.
// - Current code 0x2000 is zero current; below is discharge, above is charge.
// - Current code span maps symmetrically from minus to plus half reference, post-gain.
// - Current-amp disabled and channel skipped: stored data kept; readback per filter select.
// - Each voltage result presents its 14-bit conversion in bits 15:2.
// - Voltage result code spans a 5V full-scale input over 14-bit codes.
// - Channel measure enable clear and skipped: stored data not updated; readback per filter.
// - All result registers are read-only; host writes leave contents unaltered.
package mrr_pkg;

  // ==========================================================
  // Register indices (printed offsets); byte address is four times the index
  localparam logic [7:0] IDX_CURRENT_SENSE_RESULT = 8'h46;
  localparam logic [7:0] IDX_VOLTAGE_CH1_RESULT = 8'h47;
  localparam logic [7:0] IDX_VOLTAGE_CH2_RESULT = 8'h48;
  localparam logic [7:0] IDX_VOLTAGE_CH3_RESULT = 8'h49;
  localparam logic [7:0] IDX_VOLTAGE_CH4_RESULT = 8'h4A;
  localparam logic [7:0] IDX_RESULT_CONTROL = 8'h50;
  localparam logic [7:0] IDX_RESULT_STATUS = 8'h51;
  localparam int unsigned ADDR_IDX_LSB = 2;
  localparam int unsigned ADDR_IDX_MSB = 9;

  // ==========================================================
  // Field layout
  localparam int unsigned NUM_VOLT = 4;
  localparam int unsigned NUM_CHAN = 5;
  localparam int unsigned CODE_W = 14;
  localparam int unsigned REG_W = 16;
  localparam int unsigned CODE_LSB = 2;
  localparam int unsigned GAIN_W = 2;
  localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
  localparam logic [CODE_W-1:0] CURRENT_ZERO_CODE = 14'h2000;
  localparam logic [1:0] LOW_BITS = 2'h0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int unsigned FULL_SCALE_MV = 5000;

  // Control register fields
  localparam int unsigned CTL_CUR_EN_BIT = 0;
  localparam int unsigned CTL_CH_EN_LSB = 1;
  localparam int unsigned CTL_GAIN_LSB = 5;
  localparam int unsigned CTL_FILT_BIT = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [CODE_W-1:0] raw;
    logic [CODE_W-1:0] filt;
  } mrr_sample_t;

  typedef enum logic [2:0] {
    MRR_IDLE = 3'b001,
    MRR_ACCESS = 3'b010,
    MRR_DONE = 3'b100
  } mrr_apb_st_t;

endpackage : mrr_pkg

// [src/mrr_result_slot.sv]
// One result slot: holds raw and filtered codes of one channel
`timescale 1ns/1ps
module mrr_result_slot (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Load
  input wire logic i_load,
  input wire logic i_enable,
  input wire logic [13:0] i_raw,
  input wire logic [13:0] i_filt,
  // Readback
  input wire logic i_filt_sel,
  output logic [15:0] o_word
);

  logic [13:0] raw_q;
  logic [13:0] filt_q;

  // Skipped or disabled channels keep their last data
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      raw_q <= mrr_pkg::CODE_RESET;
      filt_q <= mrr_pkg::CODE_RESET;
    end
    else if (i_load && i_enable)
    begin
      raw_q <= i_raw;
      filt_q <= i_filt;
    end
  end

  // Readback source is chosen even while the slot holds stale data
  always_comb
  begin
    o_word = {(i_filt_sel ? filt_q : raw_q), mrr_pkg::LOW_BITS};
  end

endmodule : mrr_result_slot

// [src/mrr_result_regs.sv]
// Top: measurement result register bank behind an APB slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module mrr_result_regs (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Conversion results from the scan engine, same clock
  input wire mrr_pkg::mrr_sample_t i_sample,
  // Configuration seen by the analog front end
  output logic o_current_amp_enable,
  output logic [3:0] o_channel_measure_enable,
  output logic [1:0] o_current_amp_gain
);

  // ==========================================================
  // Control register
  logic [7:0] ctl_q;
  logic [4:0] loaded_q;
  logic [15:0] words [0:4];
  logic [4:0] enables;
  logic [7:0] idx;
  logic access;
  logic hit;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [4:0] chan_sel;

  function automatic logic [4:0] chan_onehot(input logic [2:0] c);
    logic [4:0] v;
    v = 5'h00;
    if (c < 3'h5)
    begin
      v[c] = 1'b1;
    end
    return v;
  endfunction : chan_onehot

  function automatic logic is_result(input logic [7:0] x);
    return (x >= mrr_pkg::IDX_CURRENT_SENSE_RESULT) && (x <= mrr_pkg::IDX_VOLTAGE_CH4_RESULT);
  endfunction : is_result

  // Decoded once so each slot can pick its own bit
  assign chan_sel = chan_onehot(i_sample.chan);
  assign idx = i_paddr[mrr_pkg::ADDR_IDX_MSB:mrr_pkg::ADDR_IDX_LSB];
  assign access = i_psel && i_penable;
  assign hit = is_result(idx) || (idx == mrr_pkg::IDX_RESULT_CONTROL)
             || (idx == mrr_pkg::IDX_RESULT_STATUS);

  // Only control is writable; writes to result words are dropped silently
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctl_q <= mrr_pkg::CTL_RESET;
    end
    else if (access && i_pwrite && (idx == mrr_pkg::IDX_RESULT_CONTROL) && i_pstrb[0])
    begin
      ctl_q <= i_pwdata[7:0];
    end
  end

  assign o_current_amp_enable = ctl_q[mrr_pkg::CTL_CUR_EN_BIT];
  assign o_channel_measure_enable = ctl_q[mrr_pkg::CTL_CH_EN_LSB +: mrr_pkg::NUM_VOLT];
  assign o_current_amp_gain = ctl_q[mrr_pkg::CTL_GAIN_LSB +: mrr_pkg::GAIN_W];
  assign enables = {o_channel_measure_enable, o_current_amp_enable};

  // ==========================================================
  // Result slots: 0 is current (bipolar, zero current at mid code), 1..4 voltage
  // Codes are taken as delivered; gain, bipolar offset and 5V span are analog-side
  genvar g;
  generate
    for (g = 0; g < mrr_pkg::NUM_CHAN; g++)
    begin : g_slot
      mrr_result_slot u_slot (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_load(i_sample.valid && chan_sel[g]),
        .i_enable(enables[g]),
        .i_raw(i_sample.raw),
        .i_filt(i_sample.filt),
        .i_filt_sel(ctl_q[mrr_pkg::CTL_FILT_BIT]),
        .o_word(words[g])
      );
    end
  endgenerate

  // Status: which slots have been updated since reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      loaded_q <= 5'h00;
    end
    else if (i_sample.valid)
    begin
      loaded_q <= loaded_q | (chan_sel & enables);
    end
  end

  // ==========================================================
  // Read path, registered; answer in the first access cycle
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (is_result(idx))
    begin
      rdata_d = {16'h0000, words[3'(idx - mrr_pkg::IDX_CURRENT_SENSE_RESULT)]};
    end
    else if (idx == mrr_pkg::IDX_RESULT_CONTROL)
    begin
      rdata_d = {24'h00_0000, ctl_q};
    end
    else if (idx == mrr_pkg::IDX_RESULT_STATUS)
    begin
      rdata_d = {27'h000_0000, loaded_q};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign o_prdata = rdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit;

endmodule : mrr_result_regs

// [tb/mrr_result_regs_properties.sv]
// Checker for the result register bank, bound to its ports
`timescale 1ns/1ps
module mrr_result_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Scan engine and front end
  input wire mrr_pkg::mrr_sample_t i_sample,
  input wire logic o_current_amp_enable,
  input wire logic [3:0] o_channel_measure_enable,
  input wire logic [1:0] o_current_amp_gain
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] idx;
  logic [4:0] en;
  logic [6:0] ctl;
  logic acc;
  logic bad;
  assign idx = i_paddr[9:2];
  assign en = {o_channel_measure_enable, o_current_amp_enable};
  assign ctl = {o_current_amp_gain, o_channel_measure_enable, o_current_amp_enable};
  assign acc = i_psel && i_penable;
  assign bad = !((idx >= 8'h46 && idx <= 8'h4A) || idx == 8'h50 || idx == 8'h51);
  // Equal raw and filtered codes make the readback select irrelevant
  sequence s_load;
    i_sample.valid && i_sample.chan <= 3'h4 && en[i_sample.chan]
      && i_sample.raw == i_sample.filt;
  endsequence
  sequence s_read;
    i_psel && !i_penable && !i_pwrite && !i_sample.valid && idx == 8'h46 + $past(i_sample.chan, 2);
  endsequence
  property p_load;
    s_load ##2 s_read |=> o_prdata[15:2] == $past(i_sample.raw, 3);
  endproperty
  property p_ctl_write;
    acc && i_pwrite && idx == 8'h50 && i_pstrb[0] |=> ctl == $past(i_pwdata[6:0]);
  endproperty
  property p_ctl_hold;
    $changed(ctl) |-> $past(acc && i_pwrite && idx == 8'h50);
  endproperty
  property p_err;
    acc |-> o_pslverr == bad;
  endproperty
  property p_err_idle;
    !acc |-> !o_pslverr;
  endproperty
  property p_ready;
    o_pready;
  endproperty
  property p_pad;
    o_prdata[1:0] == 2'h0 && o_prdata[31:16] == 16'h0;
  endproperty
  property p_bad_read;
    acc && !i_pwrite && bad |-> o_prdata == 32'h0;
  endproperty
  a_load: assert property (p_load) else $error("result readback wrong");
  a_ctl_write: assert property (p_ctl_write) else $error("control not taken");
  a_ctl_hold: assert property (p_ctl_hold) else $error("control changed alone");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_err_idle: assert property (p_err_idle) else $error("slave error when idle");
  a_ready: assert property (p_ready) else $error("ready low");
  a_pad: assert property (p_pad) else $error("pad bits not zero");
  a_bad_read: assert property (p_bad_read) else $error("unmapped read not zero");
endmodule : mrr_result_chk

bind mrr_result_regs mrr_result_chk u_chk (.i_sys_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_sample,
  .o_current_amp_enable, .o_channel_measure_enable, .o_current_amp_gain);

// [tb/mrr_result_regs_tb.sv]
// Self-checking bench for the result register bank
`timescale 1ns/1ps
module mrr_result_regs_tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rdy, err, cen;
  logic [31:0] addr = 0, wd = 0, rd, q;
  logic [3:0] strb = 4'hF, chen;
  logic [1:0] gain;
  logic [13:0] code [5] = '{14'h2000, 14'h3FFF, 14'h0001, 14'h1555, 14'h2AAA};
  mrr_pkg::mrr_sample_t smp = '0;
  int error_cnt = 0, checks = 0;
  mrr_result_regs DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(strb), .o_prdata(rd),
    .o_pready(rdy), .o_pslverr(err), .i_sample(smp), .o_current_amp_enable(cen),
    .o_channel_measure_enable(chen), .o_current_amp_gain(gain));
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] ew(input logic [13:0] c);
    return {16'h0, c, 2'h0};
  endfunction : ew
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // ==========
  // Bus cycles; error flag and data taken at the completing edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= {22'h0, idx, 2'h0};
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rd;
    chk({31'h0, err}, {31'h0, !((idx >= 8'h46 && idx <= 8'h4A) || idx == 8'h50 || idx == 8'h51)});
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle edge so a following call never reassigns psel in the same step
    @(posedge clk);
  endtask : xfer
  task automatic ld(input logic [2:0] ch, input logic [13:0] r, input logic [13:0] f);
    smp <= {1'b1, ch, r, f};
    @(posedge clk);
    smp <= '0;
    @(posedge clk);
  endtask : ld
  // ==========
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 7; i++)
    begin
      xfer(0, 8'h46 + i[7:0], 0);
      chk(q, 0);
    end
  endtask : t_reset
  task automatic t_load;
    xfer(1, 8'h50, 32'h7F);
    chk({25'h0, gain, chen, cen}, 32'h7F);
    for (int i = 0; i < 5; i++) ld(i[2:0], code[i], ~code[i]);
    for (int i = 0; i < 5; i++)
    begin
      xfer(0, 8'h46 + i[7:0], 0);
      chk(q, ew(code[i]));
    end
    xfer(1, 8'h50, 32'hFF);
    for (int i = 0; i < 5; i++)
    begin
      xfer(0, 8'h46 + i[7:0], 0);
      chk(q, ew(~code[i]));
    end
  endtask : t_load
  task automatic t_skip;
    xfer(1, 8'h50, 32'h1A);
    ld(0, 14'h1111, 14'h1111);
    ld(2, 14'h2222, 14'h2222);
    ld(1, 14'h0ABC, 14'h0ABC);
    xfer(0, 8'h46, 0);
    chk(q, ew(code[0]));
    xfer(0, 8'h48, 0);
    chk(q, ew(code[2]));
    xfer(0, 8'h47, 0);
    chk(q, ew(14'h0ABC));
  endtask : t_skip
  task automatic t_ro;
    for (int i = 0; i < 5; i++) xfer(1, 8'h46 + i[7:0], 32'hFFFFFFFF);
    xfer(0, 8'h49, 0);
    chk(q, ew(code[3]));
    xfer(0, 8'h60, 0);
    chk(q, 0);
  endtask : t_ro
  task automatic end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_load();
    t_skip();
    t_ro();
    end_sim();
  end
endmodule : mrr_result_regs_tb
